// *** verilog/lcdc_pkg.sv ***
// lcd drive control: shared offsets, field positions, reset values and timing
// assumes a 100 MHz system clock and a 32768 Hz low-frequency oscillator rate
package lcdc_pkg;
  localparam logic [15:0] IDX_DRIVE_CTRL = 16'hFF60;
  localparam logic [15:0] IDX_OVERRIDE   = 16'hFF61;
  localparam logic [15:0] IDX_CONTRAST   = 16'hFF62;
  localparam logic [15:0] IDX_STATUS     = 16'hFF63;
  localparam logic [15:0] IDX_DMEM_FIRST = 16'hF000;
  localparam logic [15:0] IDX_DMEM_LAST  = 16'hF09F;
  localparam int          DMEM_WORDS     = 160;
  localparam int          SEG_COUNT      = 64;
  localparam int          COM_MAX        = 8;
  // drive control fields
  localparam int BIT_SUPPLY_ON = 0;
  localparam int BIT_STATIC    = 1;
  localparam int BIT_DUTY_LO   = 2;
  localparam int BIT_DUTY_HI   = 3;
  // override fields
  localparam int BIT_RATE_SEL  = 0;
  localparam int BIT_ALL_LIT   = 1;
  localparam int BIT_ALL_DARK  = 2;
  localparam logic [3:0] RST_DRIVE_CTRL = 4'h0;
  localparam logic [2:0] RST_OVERRIDE   = 3'h4;
  localparam logic [3:0] RST_CONTRAST   = 4'h0;
  localparam logic [1:0] DUTY_1_5       = 2'h1;
  // timing
  localparam int CLK_HZ         = 100_000_000;
  localparam int LF_OSC_HZ      = 32768;
  localparam int OSC_DIV_DEF    = CLK_HZ / LF_OSC_HZ;
  localparam int FRAME_FAST_DHZ = 320;
  localparam int FRAME_SLOW_DHZ = 256;

  function automatic logic [3:0] common_count(input logic [1:0] duty);
    if (duty[1]) return 4'h8;
    else if (duty[0]) return 4'h5;
    else return 4'h4;
  endfunction

  // oscillator ticks spent on each common
  function automatic logic [8:0] ticks_per_common(input logic [1:0] duty,
                                                  input logic       rate_slow);
    int dhz;
    dhz = (rate_slow || duty == DUTY_1_5) ? FRAME_SLOW_DHZ : FRAME_FAST_DHZ;
    return 9'((LF_OSC_HZ * 10) / (dhz * int'(common_count(duty))));
  endfunction
endpackage

// *** verilog/lcdc_frame_if.sv ***
// lcd drive control: frame settings to the timing generator, common index back
// assumes both ends share clk_i
interface lcdc_frame_if;
  logic [1:0] duty;
  logic       rate_slow;
  logic       run;
  logic [2:0] common_idx;
  modport gen  (input duty, rate_slow, run, output common_idx);
  modport user (output duty, rate_slow, run, input common_idx);
endinterface

// *** verilog/lcdc_frame_gen.sv ***
// lcd drive control: frame timing from an oscillator-rate enable
// assumes synchronous active-high reset, settings stable while running
module lcdc_frame_gen
  import lcdc_pkg::*;
#(
  parameter int OSC_DIV = OSC_DIV_DEF
) (
  input  logic      clk_i,
  input  logic      rst_i,
  lcdc_frame_if.gen frm
);
  if (OSC_DIV < 2 || OSC_DIV > 4096) begin : g_bad_div
    $error("OSC_DIV out of range");
  end

  logic [11:0] osc_cnt_reg, osc_cnt_next;
  logic [8:0]  step_reg, step_next;
  logic [2:0]  idx_reg, idx_next;
  logic [8:0]  per;
  logic        osc_tick;

  always_comb begin
    per          = ticks_per_common(frm.duty, frm.rate_slow);
    osc_tick     = (osc_cnt_reg == 12'(OSC_DIV - 1));
    osc_cnt_next = osc_tick ? 12'h000 : osc_cnt_reg + 12'h001;
    step_next    = step_reg;
    idx_next     = idx_reg;
    if (!frm.run) begin
      step_next = 9'h000;
      idx_next  = 3'h0;
    end else if ({1'b0, idx_reg} >= common_count(frm.duty)) begin
      // duty cut while running: restart at common 0 at once
      step_next = 9'h000;
      idx_next  = 3'h0;
    end else if (osc_tick) begin
      if (step_reg >= per - 9'h001) begin
        step_next = 9'h000;
        // step through the commons of the duty once per frame
        if ({1'b0, idx_reg} >= common_count(frm.duty) - 4'h1) idx_next = 3'h0;
        else idx_next = idx_reg + 3'h1;
      end else begin
        step_next = step_reg + 9'h001;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      osc_cnt_reg <= 12'h000;
      step_reg    <= 9'h000;
      idx_reg     <= 3'h0;
    end else begin
      osc_cnt_reg <= osc_cnt_next;
      step_reg    <= step_next;
      idx_reg     <= idx_next;
    end
  end

  assign frm.common_idx = idx_reg;

  property p_idx_in_duty;
    @(posedge clk_i) disable iff (rst_i)
      $stable(frm.duty) |-> ({1'b0, idx_reg} < common_count(frm.duty));
  endproperty
  a_idx_in_duty: assert property (p_idx_in_duty) else $error("common beyond duty");

  property p_fifth_fixed;
    @(posedge clk_i) disable iff (rst_i)
      (frm.duty == DUTY_1_5) |-> (per == 9'h100);
  endproperty
  a_fifth_fixed: assert property (p_fifth_fixed) else $error("1/5 duty not 25.6 Hz");

  property p_rate_sel;
    @(posedge clk_i) disable iff (rst_i)
      (frm.duty == 2'h0) |-> (per == (frm.rate_slow ? 9'h140 : 9'h100));
  endproperty
  a_rate_sel: assert property (p_rate_sel) else $error("1/4 duty frame rate wrong");

  property p_step_advance;
    @(posedge clk_i) disable iff (rst_i)
      (frm.run && osc_tick && step_reg == per - 9'h001 && $stable(frm.duty)
       && idx_reg != 3'h0 && frm.duty[1]) |=> (idx_reg != $past(idx_reg));
  endproperty
  a_step_advance: assert property (p_step_advance) else $error("common did not step");
endmodule // lcdc_frame_gen

// *** verilog/lcdc_disp_mem.sv ***
// lcd drive control: 160 x 4 display memory with segment row views
// assumes writes are gated to valid word addresses by the caller
module lcdc_disp_mem
  import lcdc_pkg::*;
(
  input  logic        clk_i,
  input  logic        we_i,
  input  logic [7:0]  addr_i,
  input  logic [3:0]  wdata_i,
  output logic [3:0]  rdata_o,
  input  logic [2:0]  row_i,
  output logic [63:0] row_o,
  output logic [63:0] row0_o,
  output logic [63:0] any_o
);
  // contents not reset: software must initialise them
  logic [3:0] mem [DMEM_WORDS];

  always_ff @(posedge clk_i) begin
    if (we_i) mem[addr_i] <= wdata_i;
  end

  // segment s on common c sits at word c*16 + s/4, bit s%4
  always_comb begin
    rdata_o = (int'(addr_i) < DMEM_WORDS) ? mem[addr_i] : 4'h0;
    row_o   = '0;
    row0_o  = '0;
    any_o   = '0;
    for (int s = 0; s < SEG_COUNT; s++) begin
      row_o[s]  = mem[{row_i, 4'(s / 4)}][s % 4];
      row0_o[s] = mem[s / 4][s % 4];
      for (int c = 0; c < COM_MAX; c++) begin
        any_o[s] = any_o[s] | mem[c * 16 + s / 4][s % 4];
      end
    end
  end
endmodule // lcdc_disp_mem

// *** verilog/lcdc_top.sv ***
// lcd drive control: wishbone registers, display memory, segment and common drive
// assumes a classic wishbone master on clk_i and synchronous active-high reset
// Overview of operation
// - four-bit contrast code, 0 lightest to 15 darkest, sets drive level
// - reset clears contrast code to zero
// - external supply option makes the contrast code have no effect
// - supply bit on starts generator, off grounds drive; reads back
// - supply bit never affects segments built as DC logic outputs
// - reset clears supply, duty, static, rate, all-lit; sets all-dark
// - duty field selects 1/8, 1/5 or 1/4 on matching commons
// - drive-method bit: 1 static, 0 dynamic; reads back, resets dynamic
// - 1/4 or 1/8 duty: rate bit 1 gives 25.6 Hz, 0 gives 32 Hz
// - 1/5 duty always runs at 25.6 Hz
// - all-lit drives every non-DC segment on while supply is on, memory untouched
// - all-dark drives every non-DC segment off, memory untouched
// - all-lit wins over all-dark
// - top bit of override register reads zero, writes ignored
// - 160 words of read/write display memory, undefined after reset
// - memory bit 1 lights its segment on its common, 0 leaves it dark
// - static drive lights a segment if any of its eight bits is set
// - static drive only possible with external half-bias option
//
// Chosen here: the Wishbone slave port.
module lcdc_top
  import lcdc_pkg::*;
#(
  parameter bit          EXT_SUPPLY    = 1'b0,
  parameter bit          EXT_HALF_BIAS = 1'b0,
  parameter logic [63:0] DC_SEG_MASK   = 64'h0000_0000_0000_0000,
  parameter int          OSC_DIV       = OSC_DIV_DEF
) (
  input  logic        clk_i,
  input  logic        rst_i,
  input  logic        wb_cyc_i,
  input  logic        wb_stb_i,
  input  logic        wb_we_i,
  input  logic [17:0] wb_adr_i,
  input  logic [31:0] wb_dat_i,
  input  logic [3:0]  wb_sel_i,
  output logic [31:0] wb_dat_o,
  output logic        wb_ack_o,
  output logic        lcd_supply_on_o,
  output logic [3:0]  drive_level_o,
  output logic        static_drive_o,
  output logic [7:0]  common_line_o,
  output logic [63:0] segment_line_o
);
  lcdc_frame_if frm ();

  logic [3:0]  ctrl_reg, ctrl_next;
  logic [2:0]  ovr_reg, ovr_next;
  logic [3:0]  contrast_reg, contrast_next;
  logic        ack_reg, ack_next;
  logic [31:0] rdat_reg, rdat_next;
  logic [63:0] seg_reg, seg_next;
  logic [7:0]  com_reg, com_next;
  logic [3:0]  level_reg, level_next;
  logic [15:0] row0_wr_reg, row0_wr_next;

  logic [15:0] idx;
  logic        req, wr_en, dmem_hit, dmem_we;
  logic        static_eff;
  logic [3:0]  dmem_rdata;
  logic [63:0] row_bits, row0_bits, any_bits;
  logic [63:0] dc_known;

  assign idx        = wb_adr_i[17:2];
  assign req        = wb_cyc_i & wb_stb_i & ~ack_reg;
  assign wr_en      = req & wb_we_i & wb_sel_i[0];
  assign dmem_hit   = (idx >= IDX_DMEM_FIRST) && (idx <= IDX_DMEM_LAST);
  assign dmem_we    = wr_en & dmem_hit;
  assign static_eff = ctrl_reg[BIT_STATIC] & EXT_HALF_BIAS;

  assign frm.duty      = {ctrl_reg[BIT_DUTY_HI], ctrl_reg[BIT_DUTY_LO]};
  assign frm.rate_slow = ovr_reg[BIT_RATE_SEL];
  assign frm.run       = ctrl_reg[BIT_SUPPLY_ON];

  lcdc_frame_gen #(
    .OSC_DIV (OSC_DIV)
  ) u_frame (
    .clk_i (clk_i),
    .rst_i (rst_i),
    .frm   (frm)
  );

  lcdc_disp_mem u_dmem (
    .clk_i   (clk_i),
    .we_i    (dmem_we),
    .addr_i  (idx[7:0]),
    .wdata_i (wb_dat_i[3:0]),
    .rdata_o (dmem_rdata),
    .row_i   (frm.common_idx),
    .row_o   (row_bits),
    .row0_o  (row0_bits),
    .any_o   (any_bits)
  );

  // register file and bus answer: ack one cycle after the request
  always_comb begin
    ctrl_next     = ctrl_reg;
    ovr_next      = ovr_reg;
    contrast_next = contrast_reg;
    ack_next      = req;
    rdat_next     = rdat_reg;
    row0_wr_next  = row0_wr_reg;
    if (wr_en) begin
      unique case (idx)
        IDX_DRIVE_CTRL: ctrl_next     = wb_dat_i[3:0];
        IDX_OVERRIDE:   ovr_next      = wb_dat_i[2:0];
        IDX_CONTRAST:   contrast_next = wb_dat_i[3:0];
        default:        ;
      endcase
    end
    // row 0 words written since reset, so dc checks skip unknown memory
    if (dmem_we && idx[7:4] == 4'h0) row0_wr_next[idx[3:0]] = 1'b1;
    if (req) begin
      rdat_next = 32'h0000_0000;
      if (dmem_hit) rdat_next[3:0] = dmem_rdata;
      unique case (idx)
        IDX_DRIVE_CTRL: rdat_next[3:0] = ctrl_reg;
        IDX_OVERRIDE:   rdat_next[3:0] = {1'b0, ovr_reg};
        IDX_CONTRAST:   rdat_next[3:0] = contrast_reg;
        IDX_STATUS:     rdat_next[3:0] = {static_eff, frm.common_idx};
        default:        ;
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctrl_reg     <= RST_DRIVE_CTRL;
      ovr_reg      <= RST_OVERRIDE;
      contrast_reg <= RST_CONTRAST;
      ack_reg      <= 1'b0;
      rdat_reg     <= 32'h0000_0000;
      row0_wr_reg  <= 16'h0000;
    end else begin
      ctrl_reg     <= ctrl_next;
      ovr_reg      <= ovr_next;
      contrast_reg <= contrast_next;
      ack_reg      <= ack_next;
      rdat_reg     <= rdat_next;
      row0_wr_reg  <= row0_wr_next;
    end
  end

  // drive outputs
  always_comb begin
    logic norm;
    logic lit;
    norm     = 1'b0;
    lit      = 1'b0;
    seg_next = '0;
    dc_known = '0;
    for (int s = 0; s < SEG_COUNT; s++) begin
      dc_known[s] = DC_SEG_MASK[s] & row0_wr_reg[s / 4];
      norm = static_eff ? any_bits[s] : row_bits[s];
      lit  = ovr_reg[BIT_ALL_LIT] | (~ovr_reg[BIT_ALL_DARK] & norm);
      if (DC_SEG_MASK[s]) seg_next[s] = row0_bits[s];
      else seg_next[s] = ctrl_reg[BIT_SUPPLY_ON] & lit;
    end
    if (!ctrl_reg[BIT_SUPPLY_ON]) com_next = 8'h00;
    else if (static_eff) com_next = 8'hFF;
    else com_next = 8'h01 << frm.common_idx;
    level_next = EXT_SUPPLY ? 4'h0 : contrast_reg;
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      seg_reg   <= '0;
      com_reg   <= 8'h00;
      level_reg <= 4'h0;
    end else begin
      seg_reg   <= seg_next;
      com_reg   <= com_next;
      level_reg <= level_next;
    end
  end

  assign wb_ack_o        = ack_reg;
  assign wb_dat_o        = rdat_reg;
  assign lcd_supply_on_o = ctrl_reg[BIT_SUPPLY_ON];
  assign drive_level_o   = level_reg;
  assign static_drive_o  = static_eff;
  assign common_line_o   = com_reg;
  assign segment_line_o  = seg_reg;

  property p_reset_vals;
    @(posedge clk_i) disable iff (rst_i)
      $past(rst_i) |-> (ctrl_reg == 4'h0 && ovr_reg == 3'h4 && contrast_reg == 4'h0);
  endproperty
  a_reset_vals: assert property (p_reset_vals) else $error("bad reset values");

  property p_all_lit;
    @(posedge clk_i) disable iff (rst_i)
      (ctrl_reg[BIT_SUPPLY_ON] && ovr_reg[BIT_ALL_LIT])
        |=> ((segment_line_o & ~DC_SEG_MASK) == ~DC_SEG_MASK);
  endproperty
  a_all_lit: assert property (p_all_lit) else $error("all-lit not on");

  property p_all_dark;
    @(posedge clk_i) disable iff (rst_i)
      (ovr_reg[BIT_ALL_DARK] && !ovr_reg[BIT_ALL_LIT])
        |=> ((segment_line_o & ~DC_SEG_MASK) == 64'h0000_0000_0000_0000);
  endproperty
  a_all_dark: assert property (p_all_dark) else $error("all-dark not off");

  property p_normal;
    @(posedge clk_i) disable iff (rst_i)
      (ctrl_reg[BIT_SUPPLY_ON] && ovr_reg[2:1] == 2'h0 && !static_eff)
        |=> ((segment_line_o & ~DC_SEG_MASK) == ($past(row_bits) & ~DC_SEG_MASK));
  endproperty
  a_normal: assert property (p_normal) else $error("segment not from memory");

  property p_dc_seg;
    @(posedge clk_i) disable iff (rst_i)
      !$past(rst_i) |-> ((segment_line_o & $past(dc_known))
        == ($past(row0_bits) & $past(dc_known)));
  endproperty
  a_dc_seg: assert property (p_dc_seg) else $error("dc segment wrong");

  property p_level;
    @(posedge clk_i) disable iff (rst_i)
      ##1 (drive_level_o == (EXT_SUPPLY ? 4'h0 : $past(contrast_reg)));
  endproperty
  a_level: assert property (p_level) else $error("drive level wrong");

  property p_supply_off;
    @(posedge clk_i) disable iff (rst_i)
      !ctrl_reg[BIT_SUPPLY_ON] |=> (common_line_o == 8'h00);
  endproperty
  a_supply_off: assert property (p_supply_off) else $error("commons driven when off");

  property p_ovr_top_zero;
    @(posedge clk_i) disable iff (rst_i)
      (req && idx == IDX_OVERRIDE) |=> (wb_ack_o && wb_dat_o[31:3] == 29'h0000_0000);
  endproperty
  a_ovr_top_zero: assert property (p_ovr_top_zero) else $error("override top bit set");

  property p_static_gate;
    @(posedge clk_i) disable iff (rst_i)
      ctrl_reg[BIT_SUPPLY_ON]
        |=> ((common_line_o == 8'hFF) == ($past(ctrl_reg[BIT_STATIC]) && EXT_HALF_BIAS));
  endproperty
  a_static_gate: assert property (p_static_gate) else $error("static gate wrong");

  property p_ctrl_wr;
    @(posedge clk_i) disable iff (rst_i)
      (wr_en && idx == IDX_DRIVE_CTRL) |=> (ctrl_reg == $past(wb_dat_i[3:0]));
  endproperty
  a_ctrl_wr: assert property (p_ctrl_wr) else $error("drive control write lost");

  property p_ctrl_rd;
    @(posedge clk_i) disable iff (rst_i)
      (req && !wb_we_i && idx == IDX_DRIVE_CTRL) |=> (wb_dat_o[3:0] == $past(ctrl_reg));
  endproperty
  a_ctrl_rd: assert property (p_ctrl_rd) else $error("drive control readback wrong");

  property p_contrast_wr;
    @(posedge clk_i) disable iff (rst_i)
      (wr_en && idx == IDX_CONTRAST) |=> (contrast_reg == $past(wb_dat_i[3:0]));
  endproperty
  a_contrast_wr: assert property (p_contrast_wr) else $error("contrast write lost");

  property p_ovr_wr;
    @(posedge clk_i) disable iff (rst_i)
      (wr_en && idx == IDX_OVERRIDE) |=> (ovr_reg == $past(wb_dat_i[2:0]));
  endproperty
  a_ovr_wr: assert property (p_ovr_wr) else $error("override write wrong");

  property p_level_reset;
    @(posedge clk_i) disable iff (rst_i)
      $past(rst_i) |-> (drive_level_o == 4'h0);
  endproperty
  a_level_reset: assert property (p_level_reset) else $error("level not cleared");

  property p_supply_dark;
    @(posedge clk_i) disable iff (rst_i)
      !ctrl_reg[BIT_SUPPLY_ON]
        |=> ((segment_line_o & ~DC_SEG_MASK) == 64'h0000_0000_0000_0000);
  endproperty
  a_supply_dark: assert property (p_supply_dark) else $error("segments driven when off");

  property p_com_range;
    @(posedge clk_i) disable iff (rst_i)
      (ctrl_reg[BIT_SUPPLY_ON] && !static_eff && $stable(frm.duty))
        |=> ($onehot(common_line_o)
             && ({4'h0, common_line_o} < (12'h001 << common_count($past(frm.duty)))));
  endproperty
  a_com_range: assert property (p_com_range) else $error("common outside duty");

  property p_static_com;
    @(posedge clk_i) disable iff (rst_i)
      (ctrl_reg[BIT_SUPPLY_ON] && static_eff) |=> (common_line_o == 8'hFF);
  endproperty
  a_static_com: assert property (p_static_com) else $error("static commons wrong");

  property p_static_seg;
    @(posedge clk_i) disable iff (rst_i)
      (ctrl_reg[BIT_SUPPLY_ON] && static_eff && ovr_reg[2:1] == 2'h0)
        |=> ((segment_line_o & ~DC_SEG_MASK) == ($past(any_bits) & ~DC_SEG_MASK));
  endproperty
  a_static_seg: assert property (p_static_seg) else $error("static segment wrong");

  property p_lit_wins;
    @(posedge clk_i) disable iff (rst_i)
      (ctrl_reg[BIT_SUPPLY_ON] && ovr_reg[BIT_ALL_LIT] && ovr_reg[BIT_ALL_DARK])
        |=> ((segment_line_o & ~DC_SEG_MASK) == ~DC_SEG_MASK);
  endproperty
  a_lit_wins: assert property (p_lit_wins) else $error("all-dark beat all-lit");
endmodule // lcdc_top

// *** sim/lcdc_panel_model.sv ***
// passive segment panel: keeps the segment pattern last seen on each common
// assumes commons are one-hot in dynamic drive, sampled on the rising edge
module lcdc_panel_model (
  input  wire logic [7:0]  common_line_i,
  input  wire logic [63:0] segment_line_i,
  input  wire logic        clk_i,
  input  wire logic [2:0]  probe_i,
  output logic      [63:0] row_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [63:0] row_mem [8];

  always @(posedge clk_i) begin
    for (int c = 0; c < 8; c++) begin
      if (common_line_i == 8'(1 << c)) row_mem[c] <= segment_line_i;
    end
  end
  assign row_o = row_mem[probe_i];
endmodule // lcdc_panel_model

// *** sim/lcdc_tb_top.sv ***
// testbench for the lcd drive control block, self-checking
// assumes 100 MHz clock, wishbone classic register access, panel model on the outputs
module lcdc_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import lcdc_pkg::*;
  localparam int          DIV = 2;
  localparam logic [63:0] DCM = 64'h0000_0000_0000_0003;
  logic        clk_i = 1'b0;
  logic        rst_i = 1'b1;
  logic        wb_cyc_i = 1'b0;
  logic        wb_stb_i = 1'b0;
  logic        wb_we_i = 1'b0;
  logic [17:0] wb_adr_i = 18'h0_0000;
  logic [31:0] wb_dat_i = 32'h0000_0000;
  logic [3:0]  wb_sel_i = 4'h0;
  logic [31:0] wb_dat_o;
  logic        wb_ack_o, lcd_supply_on_o, static_drive_o;
  logic [3:0]  drive_level_o, rd, v;
  logic [7:0]  common_line_o;
  logic [63:0] segment_line_o, prow;
  logic [2:0]  probe = 3'h0;
  logic [15:0] lfsr = 16'h9812;
  logic [3:0]  shadow [160];
  int          miscompares = 0;
  int          num_checks = 0;
  int          cycles = 0;

  lcdc_top #(.EXT_SUPPLY(1'b0), .EXT_HALF_BIAS(1'b1), .DC_SEG_MASK(DCM), .OSC_DIV(DIV)) dut (
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i), .wb_sel_i(wb_sel_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .lcd_supply_on_o(lcd_supply_on_o),
    .drive_level_o(drive_level_o), .static_drive_o(static_drive_o),
    .common_line_o(common_line_o), .segment_line_o(segment_line_o));
  lcdc_panel_model panel (.common_line_i(common_line_o), .segment_line_i(segment_line_o),
    .clk_i(clk_i), .probe_i(probe), .row_o(prow));

  always #5 clk_i = ~clk_i;

  task automatic conclude();
    if (miscompares == 0 && num_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 80000) begin
      miscompares++;
      conclude();
    end
  end

  function automatic logic [15:0] rnd();
    lfsr = {lfsr[14:0], lfsr[15] ^ lfsr[13] ^ lfsr[12] ^ lfsr[10]};
    return lfsr;
  endfunction

  // expected pattern on common c; stat ors in commons 1 to 7 as well
  function automatic logic [63:0] exp_row(input int c, input bit stat);
    logic [63:0] r;
    for (int s = 0; s < 64; s++) begin
      r[s] = shadow[c * 16 + s / 4][s % 4];
      if (stat) for (int k = 1; k < 8; k++) r[s] |= shadow[k * 16 + s / 4][s % 4];
      if (DCM[s]) r[s] = shadow[s / 4][s % 4];
    end
    return r;
  endfunction

  function automatic int tpc(input logic [1:0] d, input logic rate);
    int n;
    n = d[1] ? 8 : (d[0] ? 5 : 4);
    return LF_OSC_HZ * 10 / (((rate || d == 2'b01) ? 256 : 320) * n) * DIV;
  endfunction

  task automatic chk_val(input string nm, input logic [63:0] e, input logic [63:0] g);
    num_checks++;
    if (g !== e) begin
      miscompares++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic chk_cnt(input string nm, input int e, input int g);
    num_checks++;
    if (g != e) begin
      miscompares++;
      $display("ERROR %s expected %0d seen %0d", nm, e, g);
    end
  endtask

  // one classic cycle; request held until ack is sampled high at a rising edge
  task automatic wb(input bit we, input logic [15:0] idx, input logic [3:0] d);
    @(posedge clk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i  <= we;
    wb_adr_i <= {idx, 2'b00};
    wb_dat_i <= {28'h000_0000, d};
    wb_sel_i <= 4'hF;
    do @(posedge clk_i); while (wb_ack_o !== 1'b1);
    rd = wb_dat_o[3:0];
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
  endtask

  task automatic rdchk(input string nm, input logic [15:0] idx, input logic [3:0] e);
    wb(1'b0, idx, 4'h0);
    chk_val(nm, 64'(e), 64'(rd));
  endtask

  task automatic settle();
    repeat (2) @(negedge clk_i);
  endtask

  // supply off while settings change, then time each common dwell
  task automatic frames(input logic [1:0] d, input logic rate);
    int n, cnt;
    n = d[1] ? 8 : (d[0] ? 5 : 4);
    wb(1'b1, IDX_DRIVE_CTRL, 4'h0);
    wb(1'b1, IDX_OVERRIDE, {3'b000, rate});
    wb(1'b1, IDX_DRIVE_CTRL, {d, 2'b01});
    chk_val("supply", 64'h1, 64'(lcd_supply_on_o));
    wait (common_line_o === 8'(1 << (n - 1)));
    wait (common_line_o === 8'h01);
    @(negedge clk_i);
    for (int k = 1; k <= n; k++) begin
      cnt = 0;
      do begin
        @(negedge clk_i);
        cnt++;
      end while (common_line_o === 8'(1 << (k - 1)));
      chk_cnt("dwell", tpc(d, rate), cnt);
      chk_val("common", 64'(1 << (k % n)), 64'(common_line_o));
    end
  endtask

  initial begin
    repeat (8) @(posedge clk_i);
    rst_i <= 1'b0;
    rdchk("ctrl", IDX_DRIVE_CTRL, RST_DRIVE_CTRL);
    rdchk("override", IDX_OVERRIDE, {1'b0, RST_OVERRIDE});
    rdchk("contrast", IDX_CONTRAST, RST_CONTRAST);
    chk_val("level", 64'h0, 64'(drive_level_o));
    wb(1'b1, IDX_OVERRIDE, 4'hF);
    rdchk("override", IDX_OVERRIDE, 4'h7);
    for (int i = 0; i < 6; i++) begin
      v = (i == 0) ? 4'h0 : (i == 1) ? 4'hF : 4'(rnd());
      wb(1'b1, IDX_CONTRAST, v);
      rdchk("contrast", IDX_CONTRAST, v);
      chk_val("level", 64'(v), 64'(drive_level_o));
    end
    for (int w = 0; w < 160; w++) begin
      shadow[w] = 4'(rnd());
      wb(1'b1, IDX_DMEM_FIRST + 16'(w), shadow[w]);
    end
    rdchk("mem_first", IDX_DMEM_FIRST, shadow[0]);
    rdchk("mem_last", IDX_DMEM_LAST, shadow[159]);
    wb(1'b1, 16'hF0A0, 4'h5);
    rdchk("past_mem", 16'hF0A0, 4'h0);
    for (int m = 0; m < 8; m++) frames(2'(m >> 1), 1'(m));
    for (int c = 0; c < 8; c++) begin
      probe = 3'(c);
      @(negedge clk_i);
      chk_val("panel_row", exp_row(c, 1'b0), prow);
    end
    rdchk("ctrl", IDX_DRIVE_CTRL, 4'hD);
    wb(1'b1, IDX_OVERRIDE, 4'h2);
    settle();
    chk_val("all_lit", ~DCM, segment_line_o & ~DCM);
    wb(1'b1, IDX_OVERRIDE, 4'h6);
    settle();
    chk_val("lit_and_dark", ~DCM, segment_line_o & ~DCM);
    wb(1'b1, IDX_OVERRIDE, 4'h4);
    settle();
    chk_val("all_dark", 64'h0, segment_line_o & ~DCM);
    wb(1'b1, IDX_OVERRIDE, 4'h0);
    wait (common_line_o === 8'h02);
    wait (common_line_o === 8'h01);
    settle();
    chk_val("restored", exp_row(0, 1'b0), segment_line_o);
    rdchk("mem_kept", IDX_DMEM_FIRST + 16'h0010, shadow[16]);
    wb(1'b1, IDX_DRIVE_CTRL, 4'h3);
    settle();
    chk_val("static_on", 64'h1, 64'(static_drive_o));
    chk_val("static_com", 64'hFF, 64'(common_line_o));
    chk_val("static_seg", exp_row(0, 1'b1), segment_line_o);
    wb(1'b1, IDX_DRIVE_CTRL, 4'h0);
    settle();
    chk_val("supply", 64'h0, 64'(lcd_supply_on_o));
    chk_val("off_com", 64'h0, 64'(common_line_o));
    chk_val("off_seg", exp_row(0, 1'b0) & DCM, segment_line_o);
    shadow[0] = ~shadow[0];
    wb(1'b1, IDX_DMEM_FIRST, shadow[0]);
    settle();
    chk_val("dc_seg", exp_row(0, 1'b0) & DCM, segment_line_o);
    wb(1'b1, IDX_DRIVE_CTRL, 4'h2);
    rdchk("status", IDX_STATUS, 4'h8);
    conclude();
  end
endmodule // lcdc_tb_top
